// ===== hw/aof_pkg.sv
// shared constants and types for the sample output formatting block
package aof_pkg;
  localparam int REG_W = 11;
  localparam int ADDR_W = 5;
  localparam int SAMPLE_W = 12;
  localparam int WORD_W = 14;
  localparam int LANE_W = 7;
  localparam int FIFO_DEPTH = 16;
  localparam int PAD_W = WORD_W - SAMPLE_W;
  // register offsets
  localparam logic [4:0] ADDR_TIMING = 5'h04;
  localparam logic [4:0] ADDR_ORDER = 5'h09;
  localparam logic [4:0] ADDR_FMT = 5'h0A;
  localparam logic [4:0] ADDR_ULOW = 5'h0B;
  localparam logic [4:0] ADDR_GAIN = 5'h0C;
  localparam logic [4:0] ADDR_DRIVE = 5'h0E;
  // writable bits of each register, everything else reads zero
  localparam logic [10:0] MASK_TIMING = 11'h700;
  localparam logic [10:0] MASK_ORDER = 11'h400;
  localparam logic [10:0] MASK_FMT = 11'h4E0;
  localparam logic [10:0] MASK_ULOW = 11'h7F0;
  localparam logic [10:0] MASK_GAIN = 11'h71F;
  localparam logic [10:0] MASK_DRIVE = 11'h3FF;
  localparam logic [10:0] REG_RESET = 11'h000;
  // field positions
  localparam int BIT_CLK_DLY = 8;
  localparam int BIT_CAP_EDGE = 9;
  localparam int BIT_DATA_SHIFT = 10;
  localparam int BIT_BYTEWISE = 10;
  localparam int BIT_FORMAT = 10;
  localparam int PAT_LSB = 5;
  localparam int ULOW_LSB = 4;
  localparam int UHIGH_LSB = 0;
  localparam int GAIN_LSB = 8;
  localparam int DBL_DATA = 0;
  localparam int DBL_CLK = 1;
  localparam int CUR_LSB = 2;
  localparam int CTERM_LSB = 4;
  localparam int DTERM_LSB = 7;
  localparam logic [2:0] GAIN_UNUSED = 3'h7;
  // pattern words
  localparam logic [13:0] WORD_ONES = 14'h3FFF;
  localparam logic [13:0] WORD_ZERO = 14'h0000;
  localparam logic [13:0] TOGGLE_A = 14'h2AAA;
  localparam logic [13:0] TOGGLE_B = 14'h1555;
  // output clock delay, quantised to whole system clock cycles
  localparam int CLK_DELAY_PS = 400;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CLK_DELAY_CYC = (CLK_DELAY_PS + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  typedef enum logic [2:0] {
    PAT_NORMAL = 3'b000,
    PAT_ZEROS = 3'b001,
    PAT_ONES = 3'b010,
    PAT_TOGGLE = 3'b011,
    PAT_RAMP = 3'b100,
    PAT_CUSTOM = 3'b101
  } aof_pat_t;
  typedef struct packed {
    logic [2:0] data_term;
    logic [2:0] clk_term;
    logic [1:0] current;
    logic clk_double;
    logic data_double;
  } aof_drive_t;
endpackage : aof_pkg

// ===== hw/aof_fifo.sv
// parameterised sample fifo with valid/ready on both sides
`timescale 1ns/1ns
module aof_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;
  // extra pointer bit tells full from empty
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_q[AW-1:0]];
  // storage
  always_ff @(posedge i_clk)
  begin
    if (i_in_valid && !full)
      mem[wr_q[AW-1:0]] <= i_in_data;
  end
  // pointers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (i_in_valid && !full)
        wr_q <= wr_q + 1'b1;
      if (i_out_ready && !empty)
        rd_q <= rd_q + 1'b1;
    end
  end
endmodule : aof_fifo

// ===== hw/aof_pattern.sv
// output word source: converter sample or one of the test patterns
`timescale 1ns/1ns
module aof_pattern (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_step,
  input wire aof_pkg::aof_pat_t i_sel,
  input wire logic i_straight,
  input wire logic [aof_pkg::SAMPLE_W-1:0] i_sample,
  input wire logic [aof_pkg::SAMPLE_W-1:0] i_custom,
  output logic [aof_pkg::WORD_W-1:0] o_word
);
  logic [aof_pkg::WORD_W-1:0] ramp_q;
  logic tog_q;
  logic [aof_pkg::SAMPLE_W-1:0] fmt;
  localparam logic [aof_pkg::PAD_W-1:0] PAD = '0;
  // core sample is offset binary; twos complement flips the msb
  assign fmt = i_straight ? i_sample
             : {~i_sample[aof_pkg::SAMPLE_W-1], i_sample[aof_pkg::SAMPLE_W-2:0]};
  // ramp and toggle restart whenever their pattern is not selected
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ramp_q <= aof_pkg::WORD_ZERO;
      tog_q <= 1'b0;
    end
    else
    begin
      // each counter only runs under its own code, so the ramp never
      // starts mid-range after a spell of the toggle pattern
      if (i_sel != aof_pkg::PAT_RAMP)
        ramp_q <= aof_pkg::WORD_ZERO;
      else if (i_step)
        ramp_q <= ramp_q + 1'b1;
      if (i_sel != aof_pkg::PAT_TOGGLE)
        tog_q <= 1'b0;
      else if (i_step)
        tog_q <= !tog_q;
    end
  end
  // selector; unused codes give zeros
  always_comb
  begin
    unique case (i_sel)
      aof_pkg::PAT_NORMAL: o_word = {fmt, PAD};
      aof_pkg::PAT_ZEROS: o_word = aof_pkg::WORD_ZERO;
      aof_pkg::PAT_ONES: o_word = aof_pkg::WORD_ONES;
      aof_pkg::PAT_TOGGLE:
        o_word = tog_q ? aof_pkg::TOGGLE_B : aof_pkg::TOGGLE_A;
      aof_pkg::PAT_RAMP: o_word = ramp_q;
      aof_pkg::PAT_CUSTOM: o_word = {i_custom, PAD};
      default: o_word = aof_pkg::WORD_ZERO;
    endcase
  end
endmodule : aof_pattern

// ===== hw/aof_top.sv
// sample output formatter: config registers, fifo, ddr lane driver
//
// Summary of operation
// - timing bit 8 set delays the output clock from its default position
// - timing bit 9 picks capture edge: 0 rising, 1 falling
// - timing bit 10 set shifts data transitions by half a clock
// - ordering bit only acts in ddr mode, not in parallel mode
// - ordering 0: even bits on rising, odd bits on falling clock
// - ordering 1: low seven bits on rising, upper bits on falling
// - format bit: 0 twos complement, 1 straight offset binary
// - pattern code 000 passes converter samples through
// - code 001 gives all zeros, code 010 all ones
// - code 011 alternates between 2AAA and 1555 each sample
// - code 100 ramps up from zero by one each sample
// - code 101 outputs the user pattern; 110 and 111 unused
// - register 0B bits 10..4 hold user pattern low seven bits
// - register 0C bits 4..0 hold user pattern high five bits
// - register 0C bits 10..8 set fine gain 0..6 dB; 111 unused
// - register 0E bits 3..2 set differential drive current
// - register 0E bit 0 doubles data current, bit 1 clock current
// - register 0E bits 9..7 set data termination, 000 none
// - register 0E bits 6..4 set clock termination, same codes
`timescale 1ns/1ns
module aof_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  // register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [aof_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [aof_pkg::REG_W-1:0] i_reg_wdata,
  output logic [aof_pkg::REG_W-1:0] o_reg_rdata,
  // converter core samples
  input wire logic i_adc_valid,
  output logic o_adc_ready,
  input wire logic [aof_pkg::SAMPLE_W-1:0] i_adc_data,
  // sample clock from outside and interface mode pin
  input wire logic i_sample_clk,
  input wire logic i_ddr_mode,
  // output pins
  output logic o_true_output_clock,
  output logic [aof_pkg::LANE_W-1:0] o_lane,
  output logic [aof_pkg::WORD_W-1:0] o_output_word,
  output logic o_underrun,
  // analog controls
  output logic [2:0] o_fine_gain,
  output aof_pkg::aof_drive_t o_drive
);

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  logic [aof_pkg::REG_W-1:0] timing_q;
  logic [aof_pkg::REG_W-1:0] order_q;
  logic [aof_pkg::REG_W-1:0] fmt_q;
  logic [aof_pkg::REG_W-1:0] ulow_q;
  logic [aof_pkg::REG_W-1:0] gain_q;
  logic [aof_pkg::REG_W-1:0] drive_q;
  logic [aof_pkg::REG_W-1:0] rdata_d;
  logic [aof_pkg::REG_W-1:0] rdata_q;
  logic [2:0] wr_gain;

  // decide whether an address hits a register
  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    hit = (a == r);
  endfunction : hit

  // gain field of the incoming write, tested for the unused code
  assign wr_gain = i_reg_wdata[aof_pkg::GAIN_LSB +: 3];

  // writes keep only assigned bits, so stray ones never reach logic
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timing_q <= aof_pkg::REG_RESET;
      order_q <= aof_pkg::REG_RESET;
      fmt_q <= aof_pkg::REG_RESET;
      ulow_q <= aof_pkg::REG_RESET;
      drive_q <= aof_pkg::REG_RESET;
    end
    else if (i_reg_wr)
    begin
      // an offset that matches no register drops the write
      if (hit(i_reg_addr, aof_pkg::ADDR_TIMING))
        timing_q <= i_reg_wdata & aof_pkg::MASK_TIMING;
      if (hit(i_reg_addr, aof_pkg::ADDR_ORDER))
        order_q <= i_reg_wdata & aof_pkg::MASK_ORDER;
      if (hit(i_reg_addr, aof_pkg::ADDR_FMT))
        fmt_q <= i_reg_wdata & aof_pkg::MASK_FMT;
      if (hit(i_reg_addr, aof_pkg::ADDR_ULOW))
        ulow_q <= i_reg_wdata & aof_pkg::MASK_ULOW;
      if (hit(i_reg_addr, aof_pkg::ADDR_DRIVE))
        drive_q <= i_reg_wdata & aof_pkg::MASK_DRIVE;
    end
  end

  // gain register kept apart: the unused gain code is refused
  // while the user pattern half of the same write still lands
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      gain_q <= aof_pkg::REG_RESET;
    else if (i_reg_wr && hit(i_reg_addr, aof_pkg::ADDR_GAIN))
    begin
      if (wr_gain == aof_pkg::GAIN_UNUSED)
        gain_q <= {gain_q[aof_pkg::GAIN_LSB +: 3],
                   i_reg_wdata[aof_pkg::GAIN_LSB-1:0]
                   & aof_pkg::MASK_GAIN[aof_pkg::GAIN_LSB-1:0]};
      else
        gain_q <= i_reg_wdata & aof_pkg::MASK_GAIN;
    end
  end

  // --------------------------------------------------------------
  // read back
  // --------------------------------------------------------------
  // unmapped offsets read zero
  always_comb
  begin
    rdata_d = '0;
    if (hit(i_reg_addr, aof_pkg::ADDR_TIMING))
      rdata_d = timing_q;
    if (hit(i_reg_addr, aof_pkg::ADDR_ORDER))
      rdata_d = order_q;
    if (hit(i_reg_addr, aof_pkg::ADDR_FMT))
      rdata_d = fmt_q;
    if (hit(i_reg_addr, aof_pkg::ADDR_ULOW))
      rdata_d = ulow_q;
    if (hit(i_reg_addr, aof_pkg::ADDR_GAIN))
      rdata_d = gain_q;
    if (hit(i_reg_addr, aof_pkg::ADDR_DRIVE))
      rdata_d = drive_q;
  end

  // read data one cycle after the strobe, held until the next read
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rdata_q <= '0;
    else if (i_reg_rd)
      rdata_q <= rdata_d;
  end

  assign o_reg_rdata = rdata_q;

  // --------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------
  logic clk_dly_en;
  logic cap_falling;
  logic data_shift;
  logic bytewise;
  logic straight;
  aof_pkg::aof_pat_t pat_sel;
  logic [aof_pkg::SAMPLE_W-1:0] custom;

  assign clk_dly_en = timing_q[aof_pkg::BIT_CLK_DLY];
  assign cap_falling = timing_q[aof_pkg::BIT_CAP_EDGE];
  assign data_shift = timing_q[aof_pkg::BIT_DATA_SHIFT];
  assign bytewise = order_q[aof_pkg::BIT_BYTEWISE];
  assign straight = fmt_q[aof_pkg::BIT_FORMAT];
  // codes 110 and 111 pass the cast; the selector turns them to zeros
  assign pat_sel = aof_pkg::aof_pat_t'(fmt_q[aof_pkg::PAT_LSB +: 3]);
  // high five from 0C above low seven from 0B
  assign custom = {gain_q[aof_pkg::UHIGH_LSB +: 5],
                   ulow_q[aof_pkg::ULOW_LSB +: 7]};

  // analog controls straight from the registers
  assign o_fine_gain = gain_q[aof_pkg::GAIN_LSB +: 3];
  assign o_drive.data_term = drive_q[aof_pkg::DTERM_LSB +: 3];
  assign o_drive.clk_term = drive_q[aof_pkg::CTERM_LSB +: 3];
  assign o_drive.current = drive_q[aof_pkg::CUR_LSB +: 2];
  assign o_drive.clk_double = drive_q[aof_pkg::DBL_CLK];
  assign o_drive.data_double = drive_q[aof_pkg::DBL_DATA];

  // --------------------------------------------------------------
  // pin synchronisers and sample clock edges
  // --------------------------------------------------------------
  logic sclk_m_q;
  logic sclk_s_q;
  logic sclk_d_q;
  logic mode_m_q;
  logic mode_s_q;
  logic rise;
  logic fall;
  logic load;

  // first stage feeds only the second stage
  // the mode pin only gates the lanes, so its sync delay costs nothing
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      sclk_d_q <= 1'b0;
      mode_m_q <= 1'b0;
      mode_s_q <= 1'b0;
    end
    else
    begin
      sclk_m_q <= i_sample_clk;
      sclk_s_q <= sclk_m_q;
      sclk_d_q <= sclk_s_q;
      mode_m_q <= i_ddr_mode;
      mode_s_q <= mode_m_q;
    end
  end

  assign rise = sclk_s_q && !sclk_d_q;
  assign fall = !sclk_s_q && sclk_d_q;
  // shifted data changes on the opposite half of the cycle
  assign load = data_shift ? fall : rise;
  // limitation: the link clock must stay well below a quarter of i_clk,
  // or its edges alias and words repeat

  // --------------------------------------------------------------
  // sample buffer and output word
  // --------------------------------------------------------------
  logic fifo_valid;
  logic [aof_pkg::SAMPLE_W-1:0] fifo_data;
  logic [aof_pkg::SAMPLE_W-1:0] sample_q;
  logic [aof_pkg::WORD_W-1:0] word;
  logic [aof_pkg::WORD_W-1:0] word_q;
  logic underrun_q;

  // core is stalled by o_adc_ready once sixteen samples wait
  aof_fifo #(
    .WIDTH(aof_pkg::SAMPLE_W),
    .DEPTH(aof_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_in_valid(i_adc_valid),
    .o_in_ready(o_adc_ready),
    .i_in_data(i_adc_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(load),
    .o_out_data(fifo_data)
  );

  // one sample per output cycle; an empty buffer repeats the last
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sample_q <= '0;
      underrun_q <= 1'b0;
    end
    else if (load)
    begin
      if (fifo_valid)
        sample_q <= fifo_data;
      underrun_q <= !fifo_valid;
    end
  end

  aof_pattern u_pattern (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_step(load),
    .i_sel(pat_sel),
    .i_straight(straight),
    .i_sample(sample_q),
    .i_custom(custom),
    .o_word(word)
  );

  // output word changes on the load edge only
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      word_q <= '0;
    else if (load)
      word_q <= word;
  end

  // the word lags its sample by one load: sample_q, then the pattern mux
  assign o_output_word = word_q;
  assign o_underrun = underrun_q;

  // --------------------------------------------------------------
  // ddr lanes and output clock
  // --------------------------------------------------------------
  logic [aof_pkg::LANE_W-1:0] lane_q;
  logic oclk_q;
  logic oclk_dly_q;
  logic [aof_pkg::WORD_W-1:0] lane_src;

  // pick the half of the word shown while the clock is high or low
  function automatic logic [6:0] half(input logic [13:0] w,
                                      input logic by_byte,
                                      input logic high);
    half = '0;
    for (int i = 0; i < aof_pkg::LANE_W; i++)
    begin
      if (by_byte)
        half[i] = high ? w[i] : w[i + aof_pkg::LANE_W];
      else
        half[i] = high ? w[2 * i] : w[2 * i + 1];
    end
  endfunction : half

  // lanes take the word being loaded in the same cycle, so no phase
  // ever opens with the previous sample's bits
  assign lane_src = load ? word : word_q;

  // parallel mode leaves the lanes quiet, ordering is ignored
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      lane_q <= '0;
    else if (!mode_s_q)
      lane_q <= '0;
    else
      lane_q <= half(lane_src, bytewise, sclk_s_q);
  end

  // capture on falling edge: clock inverted so data sits centred
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      oclk_q <= 1'b0;
      oclk_dly_q <= 1'b0;
    end
    else
    begin
      oclk_q <= sclk_s_q ^ cap_falling;
      oclk_dly_q <= oclk_q;
    end
  end

  // delay is one system clock; 400 ps cannot be finer here
  assign o_true_output_clock = (clk_dly_en && aof_pkg::CLK_DELAY_CYC > 0)
                               ? oclk_dly_q : oclk_q;
  assign o_lane = lane_q;

endmodule : aof_top

// ===== sim/aof_top_sva.sv
// port checker for the sample output formatter
`timescale 1ns/1ns
module aof_chk (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [aof_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic [aof_pkg::REG_W-1:0] i_reg_wdata,
  input wire logic [aof_pkg::REG_W-1:0] o_reg_rdata,
  input wire logic o_adc_ready,
  input wire logic i_ddr_mode,
  input wire logic [aof_pkg::LANE_W-1:0] o_lane,
  input wire logic [aof_pkg::WORD_W-1:0] o_output_word,
  input wire logic [2:0] o_fine_gain,
  input wire aof_pkg::aof_drive_t o_drive
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic [2:0] pat_q;
  logic [5:0] age_q;
  logic wr_gain;
  logic wr_drv;
  assign wr_gain = i_reg_wr && i_reg_addr == aof_pkg::ADDR_GAIN;
  assign wr_drv = i_reg_wr && i_reg_addr == aof_pkg::ADDR_DRIVE;
  // shadow of the pattern selector, aged so slow loads have settled
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pat_q <= 3'h0;
      age_q <= 6'h00;
    end
    else if (i_reg_wr && i_reg_addr == aof_pkg::ADDR_FMT)
    begin
      pat_q <= i_reg_wdata[7:5];
      age_q <= 6'h00;
    end
    else if (age_q != 6'h3F)
      age_q <= age_q + 6'h01;
  end
  chk_gain_takes: assert property (wr_gain && i_reg_wdata[10:8] != 3'h7
    |=> o_fine_gain == $past(i_reg_wdata[10:8])) else $error("gain lost");
  chk_gain_refuse: assert property (wr_gain && i_reg_wdata[10:8] == 3'h7
    |=> $stable(o_fine_gain)) else $error("unused gain code taken");
  chk_gain_hold: assert property (!wr_gain |=> $stable(o_fine_gain))
    else $error("gain moved without write");
  chk_drive_takes: assert property (wr_drv
    |=> o_drive == $past(i_reg_wdata[9:0])) else $error("drive lost");
  chk_drive_hold: assert property (!wr_drv |=> $stable(o_drive))
    else $error("drive moved without write");
  chk_timing_low: assert property (i_reg_rd && i_reg_addr == 5'h04
    |=> o_reg_rdata[7:0] == 8'h00) else $error("fixed bits read set");
  chk_lane_idle: assert property ((!i_ddr_mode) [*5] |-> o_lane == 7'h00)
    else $error("lanes active in parallel mode");
  chk_ones_word: assert property (age_q > 6'h28 && pat_q == 3'h2
    |-> o_output_word == 14'h3FFF) else $error("ones pattern wrong");
  chk_zero_word: assert property (age_q > 6'h28 && pat_q == 3'h1
    |-> o_output_word == 14'h0000) else $error("zero pattern wrong");
  cover property (wr_gain && i_reg_wdata[10:8] == 3'h7);
  cover property (!o_adc_ready);
  cover property (pat_q == 3'h3 && age_q == 6'h3F);
endmodule : aof_chk
bind aof_top aof_chk aof_chk_i (.*);

// ===== sim/aof_capture.sv
// capture-side model: rebuilds output words from the ddr lanes
`timescale 1ns/1ns
module aof_capture (
  input wire logic i_clk,
  input wire logic i_oclk,
  input wire logic i_fall,
  input wire logic i_by_byte,
  input wire logic [6:0] i_lane,
  output logic [13:0] o_word
);
  logic lvl;
  logic lvl_q = 1'b0;
  logic [1:0] run_q = 2'h0;
  logic [6:0] hi_q = 7'h00;
  logic [6:0] lo_q = 7'h00;
  // falling-edge capture means the true phase is the inverted clock
  assign lvl = i_oclk ^ i_fall;
  // sample mid-half, not at the edge, where lanes may still move
  always @(posedge i_clk)
  begin
    lvl_q <= lvl;
    run_q <= (lvl != lvl_q) ? 2'h0 : (run_q == 2'h3 ? run_q : run_q + 2'h1);
    if (lvl == lvl_q && run_q == 2'h1 && lvl)
      hi_q <= i_lane;
    if (lvl == lvl_q && run_q == 2'h1 && !lvl)
      lo_q <= i_lane;
    if (lvl && !lvl_q && i_by_byte)
      o_word <= {lo_q, hi_q};
    if (lvl && !lvl_q && !i_by_byte)
      for (int i = 0; i < 7; i++)
      begin
        o_word[2*i] <= hi_q[i];
        o_word[2*i+1] <= lo_q[i];
      end
  end
endmodule : aof_capture

// ===== sim/tb_aof_top.sv
// self-checking bench for the sample output formatter
`timescale 1ns/1ns
module tb_aof_top;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [4:0] i_reg_addr = 5'h00;
  logic [10:0] i_reg_wdata = 11'h000;
  logic [10:0] o_reg_rdata;
  logic i_adc_valid = 1'b0;
  logic o_adc_ready;
  logic [11:0] i_adc_data = 12'h000;
  logic i_sample_clk = 1'b0;
  logic i_ddr_mode = 1'b1;
  logic o_true_output_clock;
  logic [6:0] o_lane;
  logic [13:0] o_output_word;
  logic o_underrun;
  logic [2:0] o_fine_gain;
  aof_pkg::aof_drive_t o_drive;
  logic run_link = 1'b1;
  logic fall_q = 1'b0;
  logic byte_q = 1'b0;
  logic [13:0] cap_word;
  logic [13:0] a;
  logic [13:0] b;
  int n_mismatch = 0;
  int num_checks = 0;
  int k;
  logic [4:0] adr [6] = '{5'h04, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E};
  logic [10:0] msk [6] = '{11'h700, 11'h400, 11'h4E0, 11'h7F0, 11'h01F,
                           11'h3FF};
  aof_top aof_top_i (.*);
  aof_capture aof_capture_i (.i_clk(i_clk), .i_oclk(o_true_output_clock),
    .i_fall(fall_q), .i_by_byte(byte_q), .i_lane(o_lane), .o_word(cap_word));
  // ---------------------------------------------
  // clocks, link clock offset 2 ns past our rising edge so its edges never meet ours
  // ---------------------------------------------
  always #5 i_clk = ~i_clk;
  initial
  begin
    #7;
    forever #40 i_sample_clk = run_link ? ~i_sample_clk : i_sample_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic reg_wr(input logic [4:0] ad, input logic [10:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [4:0] ad, input logic [10:0] e);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= ad;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_clk);
    #1 chk(o_reg_rdata, e);
  endtask : reg_rd
  // pattern words need a couple of link periods before both views agree
  task automatic pat(input logic [10:0] f, input logic [13:0] e);
    reg_wr(aof_pkg::ADDR_FMT, f);
    repeat (48) @(posedge i_clk);
    #1 chk(o_output_word, e);
    repeat (48) @(posedge i_clk);
    #1 chk(cap_word, e);
  endtask : pat
  // wait up to 40 cycles for the output word to move; polled 1 ns after each edge
  task automatic next_word(output logic [13:0] v);
    logic [13:0] s;
    #1 s = o_output_word;
    v = s;
    for (int n = 0; n < 40 && v === s; n++)
    begin
      @(posedge i_clk);
      #1 v = o_output_word;
    end
    if (v === s)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t word held %h, no change from %h", $time, v, s);
    end
  endtask : next_word
  task automatic push(input logic [11:0] d);
    @(posedge i_clk);
    i_adc_valid <= 1'b1;
    i_adc_data <= d;
    @(posedge i_clk);
    i_adc_valid <= 1'b0;
  endtask : push
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // watchdog: the sequence needs under 2000 cycles
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    foreach (adr[k]) reg_rd(adr[k], 11'h000);
    reg_rd(5'h05, 11'h000);
    foreach (adr[k])
    begin
      reg_wr(adr[k], 11'h7FF);
      reg_rd(adr[k], msk[k]);
    end
    chk(o_fine_gain, 3'h0);
    chk(o_drive, 10'h3FF);
    reg_wr(aof_pkg::ADDR_GAIN, 11'h61F);
    reg_wr(aof_pkg::ADDR_DRIVE, 11'h2A5);
    #1 chk(o_fine_gain, 3'h6);
    chk(o_drive, 10'h2A5);
    foreach (adr[k]) reg_wr(adr[k], 11'h000);
    reg_wr(aof_pkg::ADDR_ULOW, 11'h3C0);
    reg_wr(aof_pkg::ADDR_GAIN, 11'h015);
    for (k = 0; k < 4; k++)
    begin
      byte_q <= k[0];
      fall_q <= k[1];
      reg_wr(aof_pkg::ADDR_ORDER, {k[0], 10'h000});
      reg_wr(aof_pkg::ADDR_TIMING, k[1] ? 11'h700 : 11'h000);
      pat(11'h020, 14'h0000);
      pat(11'h040, 14'h3FFF);
      pat(11'h0A0, 14'h2AF0);
    end
    pat(11'h0C0, 14'h0000);
    reg_wr(aof_pkg::ADDR_FMT, 11'h060);
    repeat (48) @(posedge i_clk);
    next_word(a);
    next_word(b);
    chk(a ^ b, 14'h3FFF);
    chk(a == 14'h2AAA || a == 14'h1555, 1'b1);
    reg_wr(aof_pkg::ADDR_FMT, 11'h080);
    next_word(a);
    next_word(b);
    chk(a, 14'h0000);
    chk(b, 14'h0001);
    // stall the link so the buffer fills, then drain it in order
    run_link = 1'b0;
    for (k = 1; k <= 17; k++) push(12'h100 + k[11:0]);
    chk(o_adc_ready, 1'b0);
    reg_wr(aof_pkg::ADDR_FMT, 11'h400);
    run_link = 1'b1;
    a = 14'h0000;
    for (k = 0; k < 4 && a !== 14'h0404; k++) next_word(a);
    chk(a, 14'h0404);
    for (k = 2; k <= 16; k++)
    begin
      next_word(a);
      chk(a, {12'h100 + k[11:0], 2'h0});
    end
    repeat (48) @(posedge i_clk);
    #1 chk(o_underrun, 1'b1);
    chk(o_adc_ready, 1'b1);
    reg_wr(aof_pkg::ADDR_FMT, 11'h000);
    repeat (48) @(posedge i_clk);
    #1 chk(o_output_word, 14'h2440);
    i_ddr_mode <= 1'b0;
    repeat (8) @(posedge i_clk);
    #1 chk(o_lane, 7'h00);
    chk(o_output_word, 14'h2440);
    complete_run();
  end
endmodule : tb_aof_top
